// File: verilog/input_event_capture.sv
// input image, edge interrupts and pulse measurement for a small controller
// What this block does
// - pins are copied into the input image only at each scan end.
// - the output image reaches the output pins only at the refresh.
// - interrupt inputs react to an edge, so a short pulse is still seen.
// - inputs three to seven are each enabled as interrupts on their own.
// - each interrupt input picks rising or falling edge.
// - a chosen edge dispatches its handler at once, whatever the scan.
// - inputs three and four measure pulses once measurement is enabled.
// - each channel gives a width in us and a frequency in Hz.
// - a pin is counter or meter, the last command issued wins.
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "input_event_capture_defines.svh"
module input_event_capture
   import input_event_pkg::*;
(
   input  wire logic                 sys_clk,
   input  wire logic                 arst_n,
   input  wire logic [`IN_PINS-1:0]  in_pins,
   output logic      [`OUT_PINS-1:0] out_pins,
   input  wire logic                 scan_end,
   input  wire logic [3:0]           addr,
   input  wire logic [31:0]          wdata,
   input  wire logic                 wr,
   input  wire logic                 rd,
   output logic      [31:0]          rdata,
   input  wire logic                 counter_define_command,
   input  wire logic [1:0]           counter_define_channel,
   output logic      [`IRQ_CNT-1:0]  custom_handler,
   output logic      [1:0]           measurement_channel,
   output logic                      irq
);
   //------------------------------------------------------------
   // reset release and input synchronisers
   //------------------------------------------------------------
   logic                 rst_s1_reg;
   logic                 rst_n_reg;
   logic [`IN_PINS-1:0]  sync1_reg;
   logic [`IN_PINS-1:0]  sync2_reg;
   logic [`IN_PINS-1:0]  prev_reg;

   // release is synchronised so no flop leaves reset on a different edge
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1_reg <= 1'b0;
         rst_n_reg  <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n_reg  <= rst_s1_reg;
      end
   end

   // hazard: a pulse narrower than one clock can slip between samples,
   // so edges are only promised for pulses of a clock or more
   // first stage feeds only the second
   always_ff @(posedge sys_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         prev_reg  <= '0;
      end else begin
         sync1_reg <= in_pins;
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
      end
   end

   // all stages reset low, so a pin that idles high shows one rising
   // edge after release; keep its interrupt off until then
   // edges from consecutive synchronised samples
   wire [`IN_PINS-1:0] rise_w = sync2_reg & ~prev_reg;
   wire [`IN_PINS-1:0] fall_w = ~sync2_reg & prev_reg;

   //------------------------------------------------------------
   // registers
   //------------------------------------------------------------
   // index map, one 32-bit word each, narrow fields in the low bits:
   //   0  input image, read only, refreshed at scan end
   //   1  output image, reaches the pins at the next refresh
   //   2  interrupt enable, bit 0 is input three
   //   3  edge select, one for rising, zero for falling
   //   4  sticky status, write one to clear
   //      bits 4..0 pin edges, bit 5 meter 0, bit 6 meter 1
   //   5  interrupt mask, same layout as status
   //   6  meter enables, bit 0 input three, bit 1 input four
   //   8, 9   pulse widths in microseconds
   //   10, 11 frequencies in hertz
   //   unmapped indexes read zero and ignore writes
   logic [`IN_PINS-1:0]  in_image_reg;
   logic [`OUT_PINS-1:0] out_image_reg;
   logic [`IRQ_CNT-1:0]  irq_en_reg;
   logic [`IRQ_CNT-1:0]  irq_rise_reg;
   logic [7:0]           status_reg;
   logic [7:0]           mask_reg;
   logic [1:0]           meas_en_reg;

   // address decode for the write strobes; the read path decodes in its own case
   function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
      hit = (a == off);
   endfunction

   wire wr_out   = wr && hit(addr, `REG_OUT_IMAGE);
   wire wr_ien   = wr && hit(addr, `REG_IRQ_EN);
   wire wr_irise = wr && hit(addr, `REG_IRQ_RISE);
   wire wr_stat  = wr && hit(addr, `REG_STATUS);
   wire wr_mask  = wr && hit(addr, `REG_MASK);
   wire wr_meas  = wr && hit(addr, `REG_MEAS_CTRL);

   // an output write in the refresh clock itself waits for the
   // following refresh; the pins take the image as it stood before
   // scan image: pins sampled only at scan end
   always_ff @(posedge sys_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         in_image_reg  <= '0;
         out_image_reg <= '0;
         out_pins      <= '0;
      end else begin
         if (scan_end) begin
            in_image_reg <= sync2_reg;
            out_pins     <= out_image_reg;
         end
         if (wr_out) begin
            out_image_reg <= wdata[`OUT_PINS-1:0];
         end
      end
   end

   // mask shares the status layout, so bit n gates status bit n
   // the edge choice of a disabled pin is kept for when it is enabled
   // interrupt definition command: enable and edge choice per pin
   always_ff @(posedge sys_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         irq_en_reg   <= '0;
         irq_rise_reg <= '0;
         mask_reg     <= `STAT_RST;
      end else begin
         if (wr_ien) begin
            irq_en_reg <= wdata[`IRQ_CNT-1:0];
         end
         if (wr_irise) begin
            irq_rise_reg <= wdata[`IRQ_CNT-1:0];
         end
         if (wr_mask) begin
            mask_reg <= wdata[7:0];
         end
      end
   end

   //------------------------------------------------------------
   // edge interrupts and handler dispatch
   //------------------------------------------------------------
   logic [`IRQ_CNT-1:0] trig_w;
   genvar gi;
   generate
      for (gi = 0; gi < `IRQ_CNT; gi = gi + 1) begin : g_irq
         // edge only, a held level never retriggers
         assign trig_w[gi] = irq_en_reg[gi] &&
            (irq_rise_reg[gi] ? rise_w[`IRQ_LO+gi]
                              : fall_w[`IRQ_LO+gi]);
      end
   endgenerate

   // trade-off: the handler pulse is one clock, the sticky status
   // keeps the event for software that was busy when it came
   // a disabled pin still moves prev_reg, so enabling it later never
   // replays an edge that came before the enable
   // dispatch strobe goes out straight away, not at scan end
   always_ff @(posedge sys_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         custom_handler <= '0;
      end else begin
         custom_handler <= trig_w;
      end
   end

   //------------------------------------------------------------
   // measurement channels and counter ownership
   //------------------------------------------------------------
   logic [`US_CNT_W-1:0] us_cnt_reg;
   logic                 us_tick_reg;

   // the tick is registered, so it lags the count by one clock;
   // both meters see the same lag, which cancels in every result
   // count runs free from reset; results tolerate one tick of error
   // one microsecond time base
   always_ff @(posedge sys_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         us_cnt_reg  <= '0;
         us_tick_reg <= 1'b0;
      end else begin
         us_tick_reg <= (us_cnt_reg == `US_CNT_W'(`US_CYCLES - 1));
         if (us_cnt_reg == `US_CNT_W'(`US_CYCLES - 1)) begin
            us_cnt_reg <= '0;
         end else begin
            us_cnt_reg <= us_cnt_reg + 1'b1;
         end
      end
   end

   // counter 1 owns pins three and four; last command wins
   // a counter command and a meter write in one clock: counter wins,
   // the pin stays with whichever command software issues last
   wire meas_clr = counter_define_command && counter_define_channel == 2'h1;

   always_ff @(posedge sys_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         meas_en_reg <= '0;
      end else if (meas_clr) begin
         meas_en_reg <= '0;
      end else if (wr_meas) begin
         meas_en_reg <= wdata[1:0];
      end
   end

   // results straight from the meters, read through the mux
   logic [`MEAS_W-1:0] width_w [2];
   logic [`FREQ_W-1:0] freq_w  [2];
   logic [1:0]         mdone_w;
   // one meter per measurable input, own state machine and divider
   genvar gm;
   generate
      for (gm = 0; gm < 2; gm = gm + 1) begin : g_meas
         pulse_meter u_meter (
            .clk      (sys_clk),
            .rst_n    (rst_n_reg),
            .enable   (meas_en_reg[gm]),
            .us_tick  (us_tick_reg),
            .rise     (rise_w[`MEAS_LO+gm]),
            .fall     (fall_w[`MEAS_LO+gm]),
            .width_us (width_w[gm]),
            .freq_hz  (freq_w[gm]),
            .done     (mdone_w[gm])
         );
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         measurement_channel <= '0;
      end else begin
         measurement_channel <= meas_en_reg;
      end
   end

   //------------------------------------------------------------
   // sticky status, mask and interrupt line
   //------------------------------------------------------------
   // bit 7 has no source and always reads zero
   wire [7:0] events_w = {1'b0, mdone_w, trig_w};
   // set beats a same-cycle write-one clear
   wire [7:0] status_next = (status_reg & ~(wr_stat ? wdata[7:0] : 8'h00))
                            | events_w;

   // irq looks at the next status, so it rises with the status bit
   always_ff @(posedge sys_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         status_reg <= `STAT_RST;
         irq        <= 1'b0;
      end else begin
         status_reg <= status_next;
         irq        <= |(status_next & mask_reg);
      end
   end

   //------------------------------------------------------------
   // read path, data one cycle after the strobe
   //------------------------------------------------------------
   // a width or frequency read while its meter updates returns the
   // old or the new value whole, never a mix of the two
   logic [31:0] rd_mux;
   // selection by index; unmapped indexes fall to zero
   always_comb begin
      case (addr)
         `REG_IN_IMAGE:  rd_mux = {24'h000000, in_image_reg};
         `REG_OUT_IMAGE: rd_mux = {24'h000000, out_image_reg};
         `REG_IRQ_EN:    rd_mux = {27'h0000000, irq_en_reg};
         `REG_IRQ_RISE:  rd_mux = {27'h0000000, irq_rise_reg};
         `REG_STATUS:    rd_mux = {24'h000000, status_reg};
         `REG_MASK:      rd_mux = {24'h000000, mask_reg};
         `REG_MEAS_CTRL: rd_mux = {30'h00000000, meas_en_reg};
         `REG_WIDTH0:    rd_mux = {12'h000, width_w[0]};
         `REG_WIDTH1:    rd_mux = {12'h000, width_w[1]};
         `REG_FREQ0:     rd_mux = {12'h000, freq_w[0]};
         `REG_FREQ1:     rd_mux = {12'h000, freq_w[1]};
         default:        rd_mux = 32'h00000000;
      endcase
   end

   // rdata holds the last read until the next strobe
   always_ff @(posedge sys_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         rdata <= '0;
      end else if (rd) begin
         rdata <= rd_mux;
      end
   end
endmodule
`default_nettype wire

// File: verilog/input_event_capture_defines.svh
// constants for the input event capture block
`ifndef INPUT_EVENT_CAPTURE_DEFINES_SVH
`define INPUT_EVENT_CAPTURE_DEFINES_SVH
`define IN_PINS         8
`define OUT_PINS        8
`define IRQ_LO          3
`define IRQ_CNT         5
`define MEAS_LO         3
`define CLK_MHZ         40
`define US_CYCLES       (`CLK_MHZ)
`define US_CNT_W        6
`define MEAS_W          20
`define FREQ_W          20
`define ONE_SEC_US      20'hF4240
`define STAT_RST        8'h00
`define FREQ_LIMIT_HZ   10000
// register offsets
`define REG_IN_IMAGE    4'h0
`define REG_OUT_IMAGE   4'h1
`define REG_IRQ_EN      4'h2
`define REG_IRQ_RISE    4'h3
`define REG_STATUS      4'h4
`define REG_MASK        4'h5
`define REG_MEAS_CTRL   4'h6
`define REG_WIDTH0      4'h8
`define REG_WIDTH1      4'h9
`define REG_FREQ0       4'hA
`define REG_FREQ1       4'hB
// status bit positions
`define ST_MEAS0        5
`define ST_MEAS1        6
`endif

// File: verilog/input_event_pkg.sv
// types shared by the input event capture block
package input_event_pkg;
   typedef enum logic [1:0] {
      MS_IDLE = 2'b00,
      MS_HIGH = 2'b01,
      MS_LOW  = 2'b10
   } meas_state_t;
endpackage

// File: verilog/pulse_meter.sv
// one pulse measurement channel: width in us and frequency in Hz
`timescale 1ns/10ps
`default_nettype none
`include "input_event_capture_defines.svh"
module pulse_meter
   import input_event_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic                 enable,
   input  wire logic                 us_tick,
   input  wire logic                 rise,
   input  wire logic                 fall,
   output logic [`MEAS_W-1:0]        width_us,
   output logic [`FREQ_W-1:0]        freq_hz,
   output logic                      done
);
   meas_state_t               state_reg;
   logic [`MEAS_W-1:0]        hi_cnt_reg;
   logic [`MEAS_W-1:0]        per_cnt_reg;
   logic [`FREQ_W-1:0]        div_q_reg;
   logic [`MEAS_W-1:0]        div_r_reg;
   logic [`MEAS_W-1:0]        div_d_reg;
   logic                      div_busy_reg;

   // saturating counters so a stalled input never wraps into a bogus value
   wire [`MEAS_W-1:0] hi_inc  = (&hi_cnt_reg) ? hi_cnt_reg
                                              : hi_cnt_reg + 1'b1;
   wire [`MEAS_W-1:0] per_inc = (&per_cnt_reg) ? per_cnt_reg
                                               : per_cnt_reg + 1'b1;
   wire               div_go  = div_r_reg >= div_d_reg;

   // width runs rise to fall, period rise to rise, in microsecond ticks
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg    <= MS_IDLE;
         hi_cnt_reg   <= '0;
         per_cnt_reg  <= '0;
         width_us     <= '0;
         done         <= 1'b0;
      end else begin
         done <= 1'b0;
         if (!enable) begin
            state_reg <= MS_IDLE;
         end else begin
            case (state_reg)
               MS_IDLE: begin
                  if (rise) begin
                     state_reg   <= MS_HIGH;
                     hi_cnt_reg  <= '0;
                     per_cnt_reg <= '0;
                  end
               end
               MS_HIGH: begin
                  if (us_tick) begin
                     hi_cnt_reg  <= hi_inc;
                     per_cnt_reg <= per_inc;
                  end
                  if (fall) begin
                     width_us  <= hi_cnt_reg;
                     state_reg <= MS_LOW;
                  end
               end
               MS_LOW: begin
                  if (us_tick) begin
                     per_cnt_reg <= per_inc;
                  end
                  if (rise) begin
                     hi_cnt_reg  <= '0;
                     per_cnt_reg <= '0;
                     done        <= 1'b1;
                     state_reg   <= MS_HIGH;
                  end
               end
               default: state_reg <= MS_IDLE;
            endcase
         end
      end
   end

   // serial divide 1e6 / period by repeated subtraction, one step a clock; a result of N Hz takes N + 1 clocks after the load
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_q_reg    <= '0;
         div_r_reg    <= '0;
         div_d_reg    <= '0;
         div_busy_reg <= 1'b0;
         freq_hz      <= '0;
      end else if (enable && rise && state_reg == MS_LOW) begin
         div_q_reg    <= '0;
         div_r_reg    <= `ONE_SEC_US;
         div_d_reg    <= (per_cnt_reg == '0) ? `MEAS_W'(1) : per_cnt_reg;
         div_busy_reg <= 1'b1;
      end else if (div_busy_reg) begin
         if (div_go) begin
            div_r_reg <= div_r_reg - div_d_reg;
            div_q_reg <= div_q_reg + 1'b1;
         end else begin
            freq_hz      <= div_q_reg;
            div_busy_reg <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// File: dv/input_event_capture_monitor.sv
// assertion checker for the input event capture block
`timescale 1ns/10ps
`default_nettype none
`include "input_event_capture_defines.svh"
module input_event_capture_monitor
   import input_event_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        arst_n,
   input wire logic [7:0]  in_pins,
   input wire logic [7:0]  out_pins,
   input wire logic        scan_end,
   input wire logic [3:0]  addr,
   input wire logic [31:0] wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [31:0] rdata,
   input wire logic        counter_define_command,
   input wire logic [1:0]  counter_define_channel,
   input wire logic [4:0]  custom_handler,
   input wire logic [1:0]  measurement_channel,
   input wire logic        irq
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);
   // ----
   // bus decodes and a shadow of the output image
   // ----
   wire wr_out  = wr && addr == `REG_OUT_IMAGE;
   wire wr_mask = wr && addr == `REG_MASK;
   wire wr_meas = wr && addr == `REG_MEAS_CTRL;
   wire rd_img  = rd && addr == `REG_IN_IMAGE && !scan_end;
   logic [7:0] oimg_reg;
   // shadow kept here, so the pin check needs no peek inside
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n)
         oimg_reg <= 8'h00;
      else if (wr_out)
         oimg_reg <= wdata[7:0];
   end
   sequence mask_off_s;
      wr_mask && wdata[6:0] == 7'h00 ##1 !wr_mask;
   endsequence
   sequence ctr_off_s;
      counter_define_command && counter_define_channel == 2'h1 && !wr_meas
      ##1 !wr_meas;
   endsequence
   sequence meas_set_s;
      wr_meas && !counter_define_command
      ##1 !wr_meas && !counter_define_command;
   endsequence
   sequence img_twice_s;
      rd_img ##1 rd_img;
   endsequence
   AST_OUT_HOLD:
      assert property (!scan_end |=> $stable(out_pins))
      else $error("output pins moved without a refresh");
   AST_OUT_LOAD:
      assert property (scan_end && !wr_out |=> out_pins == oimg_reg)
      else $error("output pins differ from the output image");
   AST_IMG_STILL:
      assert property (img_twice_s |=> rdata == $past(rdata))
      else $error("input image moved without a scan end");
   AST_HND_ONE:
      assert property (custom_handler != 5'h00
         |=> (custom_handler & $past(custom_handler)) == 5'h00)
      else $error("handler pulse longer than one cycle");
   // a changed pin a few cycles back must explain every handler pulse
   AST_HND_CAUSE:
      assert property (custom_handler != 5'h00 |-> (custom_handler &
         ~5'(($past(in_pins, 2) ^ $past(in_pins, 6)) >> 3)) == 5'h00)
      else $error("handler pulse without a pin edge");
   AST_IRQ_OFF:
      assert property (mask_off_s |-> ##1 !irq)
      else $error("interrupt high with everything masked");
   AST_CTR_WINS:
      assert property (ctr_off_s |-> ##1 measurement_channel == 2'h0)
      else $error("meter kept after counter command");
   AST_MEAS_SET:
      assert property (meas_set_s
         |-> ##1 measurement_channel == $past(wdata[1:0], 2))
      else $error("meter enables differ from last write");
   AST_RD_HOLD:
      assert property (!rd |=> $stable(rdata))
      else $error("read data changed without a read");
endmodule
bind input_event_capture input_event_capture_monitor
   input_event_capture_monitor_i (.sys_clk, .arst_n, .in_pins, .out_pins,
   .scan_end, .addr, .wdata, .wr, .rd, .rdata, .counter_define_command,
   .counter_define_channel, .custom_handler, .measurement_channel, .irq);
`default_nettype wire

// File: dv/pin_source_model.sv
// switches and a tachometer pickup feeding the input pins
`timescale 1ns/10ps
`default_nettype none
module pin_source_model (
   input  wire logic        sys_clk,
   input  wire logic [7:0]  lvl,
   input  wire logic        wave_on,
   input  wire logic [15:0] half_cyc,
   output logic      [7:0]  pins
);
   logic [15:0] cnt_reg;
   logic        wave_reg;
   // square wave on pin three; caller keeps it below the meter limit
   always_ff @(posedge sys_clk) begin
      if (!wave_on) begin
         cnt_reg  <= 16'h0000;
         wave_reg <= 1'b0;
      end else if (cnt_reg == half_cyc - 16'h0001) begin
         cnt_reg  <= 16'h0000;
         wave_reg <= !wave_reg;
      end else begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end
   // plain levels are held by the caller across whole scans
   assign pins = {lvl[7:4], lvl[3] | wave_reg, lvl[2:0]};
endmodule
`default_nettype wire

// File: dv/input_event_capture_tb_top.sv
// self-checking bench for the input event capture block
`timescale 1ns/10ps
`default_nettype none
`include "input_event_capture_defines.svh"
module input_event_capture_tb_top
   import input_event_pkg::*;
   ;
   localparam int HALF_US = 125;
   localparam int FREQ_HZ = 1000000 / (2 * HALF_US);
   logic        sys_clk = 1'b0;
   logic        arst_n, scan_end, wr, rd, wave_on, ccmd, irq;
   logic [7:0]  in_pins, out_pins, lvl;
   logic [3:0]  addr;
   logic [31:0] wdata, rdata, rd_val;
   logic [15:0] half_cyc;
   logic [4:0]  hnd;
   logic [1:0]  cchan, mch;
   int          err_count, check_count, n, i;
   always #12.5 sys_clk = ~sys_clk;
   input_event_capture input_event_capture_i (.sys_clk, .arst_n, .in_pins,
      .out_pins, .scan_end, .addr, .wdata, .wr, .rd, .rdata,
      .counter_define_command(ccmd), .counter_define_channel(cchan),
      .custom_handler(hnd), .measurement_channel(mch), .irq);
   pin_source_model pin_source_model_i (.sys_clk, .lvl, .wave_on,
      .half_cyc, .pins(in_pins));
   // ----
   // reporting and bus tasks
   // ----
   task bad(input string m);
      err_count++;
      $display("BAD %0t %s", $time, m);
   endtask
   task cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
      check_count++;
      if (got !== exp) bad(m);
   endtask
   // tolerance of one microsecond tick on the meter results
   task near(input logic [31:0] v, input int lo, input int hi, string m);
      check_count++;
      if ((v >= lo && v <= hi) !== 1'b1) bad(m);
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask
   task rd_reg(input logic [3:0] a);
      @(posedge sys_clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1;
      rd_val = rdata;
   endtask
   task scan;
      @(posedge sys_clk);
      scan_end <= 1'b1;
      @(posedge sys_clk);
      scan_end <= 1'b0;
      #1;
   endtask
   // counts handler pulses of one pin over a short window
   task watch(input int k);
      n = 0;
      repeat (12) begin
         @(posedge sys_clk);
         #1;
         if (hnd[k] === 1'b1) n++;
      end
   endtask
   // ----
   // scenarios
   // ----
   task t_image;
      lvl <= 8'h5A;
      repeat (4) @(posedge sys_clk);
      rd <= 1'b1;
      addr <= `REG_IN_IMAGE;
      repeat (2) @(posedge sys_clk);
      rd <= 1'b0;
      #1;
      cmp(rdata, 32'h0, "image moved before scan end");
      scan;
      rd_reg(`REG_IN_IMAGE);
      cmp(rd_val, 32'h5A, "image not taken at scan end");
      lvl <= 8'h00;
      $display("image test done");
   endtask
   task t_outputs;
      wr_reg(`REG_OUT_IMAGE, 32'hA5);
      repeat (3) @(posedge sys_clk);
      #1;
      cmp(out_pins, 8'h00, "outputs moved before refresh");
      rd_reg(`REG_OUT_IMAGE);
      cmp(rd_val, 32'hA5, "output image readback");
      scan;
      cmp(out_pins, 8'hA5, "outputs not loaded at refresh");
      $display("output test done");
   endtask
   task t_irq;
      wr_reg(`REG_IRQ_EN, 32'h1F);
      for (int k = 0; k < 5; k++) begin
         for (int p = 0; p < 2; p++) begin
            wr_reg(`REG_IRQ_RISE, 32'(p) << k);
            wr_reg(`REG_MASK, 32'h0);
            lvl[3+k] <= 1'b1;
            watch(k);
            cmp(n, p, "rising edge response");
            lvl[3+k] <= 1'b0;
            watch(k);
            cmp(n, 1 - p, "falling edge response");
            rd_reg(`REG_STATUS);
            cmp(rd_val, 32'h1 << k, "status after edge");
            cmp(irq, 1'b0, "masked interrupt raised");
            wr_reg(`REG_MASK, 32'h1 << k);
            repeat (2) @(posedge sys_clk);
            #1;
            cmp(irq, 1'b1, "interrupt not raised");
            wr_reg(`REG_STATUS, 32'h1 << k);
            rd_reg(`REG_STATUS);
            cmp(rd_val, 32'h0, "status not cleared");
            cmp(irq, 1'b0, "interrupt stuck");
         end
      end
      wr_reg(`REG_IRQ_EN, 32'h0F);
      lvl[7] <= 1'b1;
      watch(4);
      cmp(n, 0, "disabled pin dispatched");
      lvl[7] <= 1'b0;
      $display("interrupt test done");
   endtask
   task t_meas;
      wr_reg(`REG_IRQ_EN, 32'h0);
      wr_reg(`REG_MEAS_CTRL, 32'h1);
      @(posedge sys_clk);
      #1;
      cmp(mch, 2'h1, "meter zero not enabled");
      half_cyc <= 16'(HALF_US * `CLK_MHZ);
      wave_on  <= 1'b1;
      rd_val = 32'h0;
      for (i = 0; i < 200 && rd_val[19:0] === 20'h0; i++) begin
         repeat (200) @(posedge sys_clk);
         rd_reg(`REG_FREQ0);
      end
      if (i == 200) begin
         bad("no frequency result");
         complete_run;
      end
      near(rd_val, FREQ_HZ - 16, FREQ_HZ + 16, "frequency");
      rd_reg(`REG_WIDTH0);
      near(rd_val, HALF_US - 1, HALF_US + 1, "pulse width");
      rd_reg(`REG_FREQ1);
      cmp(rd_val, 32'h0, "disabled meter measured");
      rd_reg(`REG_STATUS);
      cmp(rd_val[`ST_MEAS0], 1'b1, "no new period flag");
      ccmd  <= 1'b1;
      cchan <= 2'h1;
      @(posedge sys_clk);
      ccmd <= 1'b0;
      repeat (3) @(posedge sys_clk);
      #1;
      cmp(mch, 2'h0, "counter did not take the pin");
      wr_reg(`REG_MEAS_CTRL, 32'h3);
      repeat (3) @(posedge sys_clk);
      #1;
      cmp(mch, 2'h3, "last meter write lost");
      wave_on <= 1'b0;
      $display("meter test done");
   endtask
   initial begin
      arst_n   = 1'b0;
      lvl      = 8'h00;
      scan_end = 1'b0;
      wr       = 1'b0;
      rd       = 1'b0;
      addr     = 4'h0;
      wdata    = 32'h0;
      ccmd     = 1'b0;
      cchan    = 2'h0;
      wave_on  = 1'b0;
      half_cyc = 16'h0001;
      repeat (12) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      t_image;
      t_outputs;
      t_irq;
      t_meas;
      complete_run;
   end
endmodule
`default_nettype wire
